// File: design/dsram_fifo.sv
// Dual-clock FIFO with gray-coded pointers, valid and ready on both sides.
module dsram_fifo
   import dsram_pkg::*;
#(
   parameter int unsigned WIDTH = 36,
   parameter int unsigned DEPTH = 16
)
(
   // Filling side
   input wire logic wr_clk,
   input wire logic wr_rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   input wire logic rd_clk,
   input wire logic rd_rst_n,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] s1;
      logic [AW:0] s2;
   } dsram_ptr_t;

   dsram_ptr_t w_q;
   dsram_ptr_t w_d;
   dsram_ptr_t r_q;
   dsram_ptr_t r_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push;
   logic pop;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // ************************************************************
   // Filling side
   // ************************************************************
   assign in_ready = (w_q.gray != {~w_q.s2[AW:AW-1], w_q.s2[AW-2:0]});
   assign push = in_valid && in_ready;

   always_comb
   begin
      w_d = w_q;
      w_d.s1 = r_q.gray;
      w_d.s2 = w_q.s1;
      if (push)
      begin
         w_d.bin = w_q.bin + 1'b1;
         w_d.gray = to_gray(w_d.bin);
      end
   end

   always_ff @(posedge wr_clk)
   begin
      if (!wr_rst_n)
         w_q <= '0;
      else
         w_q <= w_d;
      if (push)
         mem_q[w_q.bin[AW-1:0]] <= in_data;
   end

   // ************************************************************
   // Draining side
   // ************************************************************
   assign out_valid = (r_q.gray != r_q.s2);
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[r_q.bin[AW-1:0]];

   always_comb
   begin
      r_d = r_q;
      r_d.s1 = w_q.gray;
      r_d.s2 = r_q.s1;
      if (pop)
      begin
         r_d.bin = r_q.bin + 1'b1;
         r_d.gray = to_gray(r_d.bin);
      end
   end

   always_ff @(posedge rd_clk)
   begin
      if (!rd_rst_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end

endmodule

// File: design/dsram_pkg.sv
// Shared constants, state encodings and state records of the separate-I/O burst SRAM port.
package dsram_pkg;

   // ************************************************************
   // Geometry of the wide-word variant
   // ************************************************************
   localparam int unsigned DATA_W = 36;
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned LANES = 4;
   localparam int unsigned LANE_W = 9;
   localparam int unsigned BURST_LEN = 2;
   localparam int unsigned MEM_WORDS = 1 << (ADDR_W + 1);
   localparam int unsigned FIFO_DEPTH = 16;

   // ************************************************************
   // Read latency in half periods of the output clock pair
   // ************************************************************
   localparam logic [1:0] LAT_DLL_ON_HALF = 2'h3;
   localparam logic [1:0] LAT_DLL_OFF_HALF = 2'h2;

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic RST_TRUE_PHASE = 1'h1;
   localparam logic [DATA_W-1:0] RST_DOUT = 36'h0_0000_0000;

   // ************************************************************
   // State encodings
   // ************************************************************
   typedef enum logic [1:0]
   {
      CS_IDLE = 2'b00,
      CS_WR2 = 2'b01,
      CS_RDP0 = 2'b10,
      CS_RDP1 = 2'b11
   } dsram_core_st_t;

   typedef enum logic [2:0]
   {
      RS_IDLE = 3'b000,
      RS_GET1 = 3'b001,
      RS_WAIT = 3'b010,
      RS_W0 = 3'b011,
      RS_W1 = 3'b100
   } dsram_rd_st_t;

   typedef struct packed
   {
      dsram_core_st_t st;
      logic true_ph;
      logic ready;
      logic [ADDR_W-1:0] addr;
   } dsram_core_t;

   typedef struct packed
   {
      dsram_rd_st_t st;
      logic true_ph;
      logic echo_inv;
      logic [1:0] cnt;
      logic [DATA_W-1:0] w0;
      logic [DATA_W-1:0] w1;
      logic [DATA_W-1:0] dout;
      logic oe;
   } dsram_rd_t;

endpackage

// File: design/dsram_port.sv
// Port logic of a separate-I/O double-data-rate burst SRAM: command, write and read paths.

// What this block does
// - A transaction starts only when load_strobe_n is sampled low.
// - Every access moves exactly two words per loaded address.
// - Byte selects are sampled on the same edge as their data word.
// - Select n gates nine-bit lane n of each word.
// - A deasserted select leaves that stored lane untouched.
// - One shared address is captured only on the true-phase edge.
// - Address is 18 bits for the 36-bit word; each selects a burst.
// - Address is ignored while no port is selected.
// - Read words are launched on the edges of the output clock pair.
// - Read outputs are released whenever the read port is idle.
// - access_direction high requests a read, low a write, at the load edge.
// - Accesses begin on the true-phase edge.
// - With the loop enabled read data follows after one and a half cycles.
// - With dll_disable_n low read latency shrinks to one cycle.
// - Echo strobes run freely, aligned to the output clock pair.
module dsram_port
   import dsram_pkg::*;
(
   // Input clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Output clock pair, one period of read_clk is one phase
   input wire logic read_clk,
   // Command and address
   input wire logic load_strobe_n,
   input wire logic access_direction,
   input wire logic [ADDR_W-1:0] address,
   // Write data
   input wire logic [DATA_W-1:0] incoming_write_bits,
   input wire logic [LANES-1:0] byte_write_select_n,
   // Mode
   input wire logic dll_disable_n,
   // Command status
   output logic input_true_phase,
   output logic load_ready,
   // Read data and echo strobes
   output logic [DATA_W-1:0] read_data_out,
   output logic read_data_oe,
   output logic echo_strobe_true,
   output logic echo_strobe_inv
);

   // ************************************************************
   // Storage and shared nets
   // ************************************************************
   wire logic [DATA_W-1:0] rd_word;
   dsram_core_t core_q;
   dsram_core_t core_d;
   dsram_rd_t rd_q;
   dsram_rd_t rd_d;
   logic wr_en;
   logic [ADDR_W:0] wr_idx;
   logic [LANES-1:0] wr_sel_n;
   logic [ADDR_W:0] rd_idx;
   logic push_valid;
   logic push_ready;
   logic pop_valid;
   logic pop_ready;
   logic [DATA_W-1:0] pop_data;
   logic [1:0] rd_sync;
   logic rd_rst_n;
   logic rd_dll_on;
   logic load_take;

   function automatic logic lane_on(input logic [LANES-1:0] sel_n, input int unsigned lane);
      return !sel_n[lane];
   endfunction

   // ************************************************************
   // Command and write path on the input clock
   // ************************************************************
   // A load is taken only on a true-phase edge with the port free.
   assign load_take = !load_strobe_n && core_q.true_ph && (core_q.st == CS_IDLE);

   always_comb
   begin
      core_d = core_q;
      core_d.true_ph = !core_q.true_ph;
      wr_en = 1'b0;
      wr_idx = {core_q.addr, 1'b1};
      wr_sel_n = byte_write_select_n;
      rd_idx = {core_q.addr, 1'b0};
      push_valid = 1'b0;
      unique case (core_q.st)
         CS_IDLE:
         begin
            if (load_take)
            begin
               core_d.addr = address;
               if (access_direction)
                  core_d.st = CS_RDP0;
               else
               begin
                  // First word goes in on the true-phase edge of the load.
                  wr_en = 1'b1;
                  wr_idx = {address, 1'b0};
                  core_d.st = CS_WR2;
               end
            end
         end
         CS_WR2:
         begin
            // Second word and its selects on the following complement edge.
            wr_en = 1'b1;
            wr_idx = {core_q.addr, 1'b1};
            core_d.st = CS_IDLE;
         end
         CS_RDP0:
         begin
            push_valid = 1'b1;
            rd_idx = {core_q.addr, 1'b0};
            if (push_ready)
               core_d.st = CS_RDP1;
         end
         CS_RDP1:
         begin
            push_valid = 1'b1;
            rd_idx = {core_q.addr, 1'b1};
            if (push_ready)
               core_d.st = CS_IDLE;
         end
      endcase
      // Ready is shown one edge ahead so the controller sees it as a flop.
      core_d.ready = (core_d.st == CS_IDLE) && !core_d.true_ph ? 1'b0 : (core_d.st == CS_IDLE);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         core_q.st <= CS_IDLE;
         core_q.true_ph <= RST_TRUE_PHASE;
         core_q.ready <= 1'b1;
         core_q.addr <= '0;
      end
      else
         core_q <= core_d;
   end

   // ************************************************************
   // Storage, one array per nine-bit lane
   // ************************************************************
   // Each lane owns its array, so a deselected lane is simply not written and keeps
   // its old contents without a read-modify-write of the whole word.
   for (genvar g = 0; g < LANES; g++)
   begin : g_lane
      logic [LANE_W-1:0] lane_q [MEM_WORDS];

      always_ff @(posedge clk)
      begin
         if (wr_en && lane_on(wr_sel_n, g))
            lane_q[wr_idx] <= incoming_write_bits[g*LANE_W +: LANE_W];
      end

      assign rd_word[g*LANE_W +: LANE_W] = lane_q[rd_idx];
   end

   assign input_true_phase = core_q.true_ph;
   assign load_ready = core_q.ready;

   // ************************************************************
   // Crossing into the output clock domain
   // ************************************************************
   // The FIFO stalls the read push when the output side falls behind.
   dsram_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .wr_clk(clk),
      .wr_rst_n(rst_n),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(rd_word),
      .rd_clk(read_clk),
      .rd_rst_n(rd_rst_n),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_data)
   );

   dsram_sync #(
      .W(2)
   ) u_sync (
      .clk(read_clk),
      .d({rst_n, dll_disable_n}),
      .q(rd_sync)
   );

   assign rd_rst_n = rd_sync[1];
   assign rd_dll_on = rd_sync[0];

   // ************************************************************
   // Read launch on the output clock pair
   // ************************************************************
   always_comb
   begin
      rd_d = rd_q;
      rd_d.true_ph = !rd_q.true_ph;
      rd_d.echo_inv = rd_q.true_ph;
      pop_ready = 1'b0;
      unique case (rd_q.st)
         RS_IDLE:
         begin
            pop_ready = 1'b1;
            if (pop_valid)
            begin
               rd_d.w0 = pop_data;
               rd_d.st = RS_GET1;
            end
         end
         RS_GET1:
         begin
            pop_ready = 1'b1;
            if (pop_valid)
            begin
               rd_d.w1 = pop_data;
               rd_d.cnt = rd_dll_on ? LAT_DLL_ON_HALF : LAT_DLL_OFF_HALF;
               rd_d.st = RS_WAIT;
            end
         end
         RS_WAIT:
         begin
            if (rd_q.cnt != 2'h0)
               rd_d.cnt = rd_q.cnt - 2'h1;
            else if (rd_d.true_ph)
            begin
               rd_d.dout = rd_q.w0;
               rd_d.oe = 1'b1;
               rd_d.st = RS_W0;
            end
         end
         RS_W0:
         begin
            rd_d.dout = rd_q.w1;
            rd_d.st = RS_W1;
         end
         RS_W1:
         begin
            // Release the bus as soon as the burst is out.
            rd_d.dout = RST_DOUT;
            rd_d.oe = 1'b0;
            rd_d.st = RS_IDLE;
         end
         default:
         begin
            rd_d.dout = RST_DOUT;
            rd_d.oe = 1'b0;
            rd_d.st = RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge read_clk)
   begin
      if (!rd_rst_n)
      begin
         rd_q.st <= RS_IDLE;
         rd_q.true_ph <= RST_TRUE_PHASE;
         rd_q.echo_inv <= !RST_TRUE_PHASE;
         rd_q.cnt <= 2'h0;
         rd_q.w0 <= RST_DOUT;
         rd_q.w1 <= RST_DOUT;
         rd_q.dout <= RST_DOUT;
         rd_q.oe <= 1'b0;
      end
      else
         rd_q <= rd_d;
   end

   assign read_data_out = rd_q.dout;
   assign read_data_oe = rd_q.oe;
   assign echo_strobe_true = rd_q.true_ph;
   assign echo_strobe_inv = rd_q.echo_inv;

endmodule

// File: design/dsram_sync.sv
// Two-flop level synchroniser into a destination clock domain.
module dsram_sync
   import dsram_pkg::*;
#(
   parameter int unsigned W = 1
)
(
   // Destination clock
   input wire logic clk,
   // Levels from the other domain
   input wire logic [W-1:0] d,
   // Synchronised levels
   output logic [W-1:0] q
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dsram_sync_t;

   dsram_sync_t s_q;
   dsram_sync_t s_d;

   // No reset here: this chain also carries the reset level itself.
   always_comb
   begin
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   assign q = s_q.s2;

endmodule

// File: dv/dsram_ctrl_model.sv
// Behavioural memory controller that drives the port and gathers read words.
module dsram_ctrl_model
   import dsram_pkg::*;
(
   // Clocks
   input wire logic clk,
   input wire logic read_clk,
   // Command and write data
   output logic load_strobe_n,
   output logic access_direction,
   output logic [ADDR_W-1:0] address,
   output logic [DATA_W-1:0] incoming_write_bits,
   output logic [LANES-1:0] byte_write_select_n,
   // Status and read data
   input wire logic input_true_phase,
   input wire logic load_ready,
   input wire logic [DATA_W-1:0] read_data_out,
   input wire logic read_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Controller
   // ************************************************************
   logic [DATA_W-1:0] rd_q[$];
   // Loads that gave up waiting for a free true-phase edge; the bench expects none.
   int load_stalls = 0;

   initial
   begin
      load_strobe_n = 1'b1;
      access_direction = 1'b0;
      address = '0;
      incoming_write_bits = '0;
      byte_write_select_n = 4'hf;
   end

   always @(posedge read_clk)
   begin
      if (read_data_oe === 1'b1)
         rd_q.push_back(read_data_out);
   end

   // With comp set the load lands on a complement edge, which must be ignored.
   task automatic load(input logic dir, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
         input logic [LANES-1:0] m0, input logic [LANES-1:0] m1, input logic comp);
      int n = 0;
      @(negedge clk);
      while (!(input_true_phase === !comp && (comp || load_ready === 1'b1)) && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 200)
         load_stalls++;
      load_strobe_n = 1'b0;
      access_direction = dir;
      address = a;
      incoming_write_bits = d0;
      byte_write_select_n = m0;
      @(negedge clk);
      load_strobe_n = 1'b1;
      address = ~a;
      incoming_write_bits = d1;
      byte_write_select_n = m1;
      @(negedge clk);
      incoming_write_bits = ~d1;
      byte_write_select_n = 4'hf;
   endtask
endmodule

// File: dv/dsram_port_checker.sv
// Concurrent checks on the pins of the burst SRAM port.
module dsram_port_checker
   import dsram_pkg::*;
(
   // Clocks and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic read_clk,
   // Command side
   input wire logic load_strobe_n,
   input wire logic access_direction,
   input wire logic input_true_phase,
   input wire logic load_ready,
   // Read side
   input wire logic [DATA_W-1:0] read_data_out,
   input wire logic read_data_oe,
   input wire logic echo_strobe_true,
   input wire logic echo_strobe_inv
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Assertions
   // ************************************************************
   // The read side leaves reset two edges late, so echo checks wait for it.
   logic [2:0] settle_q;
   always_ff @(posedge read_clk)
   begin
      if (!rst_n)
         settle_q <= 3'h0;
      else if (settle_q != 3'h7)
         settle_q <= settle_q + 3'h1;
   end

   reset_status_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> input_true_phase && load_ready) else $error("bad status after reset");
   phase_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> input_true_phase != $past(input_true_phase)) else $error("phase stuck");
   read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
      !load_strobe_n && access_direction && input_true_phase && load_ready
      |-> ##[4:60] read_data_oe) else $error("read load gave no data");
   out_release_a: assert property (@(posedge read_clk) disable iff (!rst_n)
      !read_data_oe |-> read_data_out == '0) else $error("data shown while released");
   burst_two_a: assert property (@(posedge read_clk) disable iff (!rst_n)
      $rose(read_data_oe) |=> read_data_oe ##1 !read_data_oe) else $error("burst not two words");
   first_true_a: assert property (@(posedge read_clk) disable iff (!rst_n)
      $rose(read_data_oe) |-> echo_strobe_true) else $error("first word off true phase");
   echo_pair_a: assert property (@(posedge read_clk) disable iff (!rst_n)
      settle_q == 3'h7 |-> echo_strobe_inv == !echo_strobe_true) else $error("echo pair skewed");
   echo_toggle_a: assert property (@(posedge read_clk) disable iff (!rst_n)
      settle_q == 3'h7 |-> echo_strobe_true != $past(echo_strobe_true)) else $error("echo stuck");
endmodule

bind dsram_port dsram_port_checker chk (.clk, .rst_n, .read_clk, .load_strobe_n,
   .access_direction, .input_true_phase, .load_ready, .read_data_out, .read_data_oe,
   .echo_strobe_true, .echo_strobe_inv);

// File: dv/tb.sv
// Self-checking bench for the burst SRAM port.
module tb
   import dsram_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed
   {
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d0;
      logic [DATA_W-1:0] d1;
      logic [LANES-1:0] m0;
      logic [LANES-1:0] m1;
   } dsram_row_t;
   dsram_row_t rows[6] = '{
      '{18'h0_0000, 36'h1_2345_6789, 36'hf_edcb_a987, 4'h0, 4'h0},
      '{18'h0_0000, 36'h0_0000_0000, 36'hf_ffff_ffff, 4'h5, 4'ha},
      '{18'h3_ffff, 36'ha_aaaa_aaaa, 36'h5_5555_5555, 4'h0, 4'h0},
      '{18'h3_ffff, 36'h0_0000_0000, 36'h0_0000_0000, 4'hf, 4'hf},
      '{18'h1_5555, 36'h8_0402_0100, 36'h0_0000_0001, 4'h0, 4'h0},
      '{18'h1_5555, 36'hf_ffff_ffff, 36'hf_ffff_ffff, 4'he, 4'h7}};
   logic clk, read_clk, rst_n, dll_disable_n, load_strobe_n, access_direction;
   logic [ADDR_W-1:0] address;
   logic [DATA_W-1:0] incoming_write_bits, read_data_out;
   logic [LANES-1:0] byte_write_select_n;
   logic input_true_phase, load_ready, read_data_oe, echo_strobe_true, echo_strobe_inv;
   logic [DATA_W-1:0] exp_q[int];
   int miscompares = 0;
   int samples_checked = 0;

   initial clk = 1'b0;
   always #4 clk = ~clk;
   initial
   begin
      read_clk = 1'b0;
      #5.3;
      forever #16 read_clk = ~read_clk;
   end

   dsram_port dut (.clk, .rst_n, .read_clk, .load_strobe_n, .access_direction, .address,
      .incoming_write_bits, .byte_write_select_n, .dll_disable_n, .input_true_phase,
      .load_ready, .read_data_out, .read_data_oe, .echo_strobe_true, .echo_strobe_inv);
   dsram_ctrl_model ctl (.clk, .read_clk, .load_strobe_n, .access_direction, .address,
      .incoming_write_bits, .byte_write_select_n, .input_true_phase, .load_ready,
      .read_data_out, .read_data_oe);

   // ************************************************************
   // Test sequence
   // ************************************************************
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Reset is held past four output clock edges so the lagging read side resets too.
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (18) @(negedge clk);
      check(36'({input_true_phase, load_ready, read_data_oe, echo_strobe_true,
         echo_strobe_inv}), 36'h1a);
      check(read_data_out, 36'h0);
      rst_n = 1'b1;
   endtask

   task automatic read_cmp(input logic [ADDR_W-1:0] a);
      int n = 0;
      ctl.load(1'b1, a, '1, '1, 4'hf, 4'hf, 1'b0);
      while (ctl.rd_q.size() < 2 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      check(36'(ctl.rd_q.size()), 36'h2);
      for (int i = 0; i < 2; i++)
         check(ctl.rd_q.size() > 0 ? ctl.rd_q.pop_front() : 'x, exp_q[a*2+i]);
   endtask

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
         input logic [DATA_W-1:0] d, input logic [LANES-1:0] m);
      merge = old;
      for (int i = 0; i < LANES; i++)
         if (!m[i])
            merge[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
   endfunction

   initial
   begin
      dll_disable_n = 1'b1;
      do_reset();
      foreach (rows[i])
      begin
         dll_disable_n = ~i[0];
         ctl.load(1'b0, rows[i].a, rows[i].d0, rows[i].d1, rows[i].m0, rows[i].m1, 1'b0);
         exp_q[rows[i].a*2] = merge(exp_q[rows[i].a*2], rows[i].d0, rows[i].m0);
         exp_q[rows[i].a*2+1] = merge(exp_q[rows[i].a*2+1], rows[i].d1, rows[i].m1);
         read_cmp(rows[i].a);
      end
      // Loads on complement edges must change nothing and return nothing.
      ctl.load(1'b0, 18'h0_0000, 36'h3_3333_3333, 36'h3_3333_3333, 4'h0, 4'h0, 1'b1);
      ctl.load(1'b1, 18'h0_0000, '1, '1, 4'hf, 4'hf, 1'b1);
      repeat (80) @(negedge clk);
      check(36'(ctl.rd_q.size()), 36'h0);
      read_cmp(18'h0_0000);
      do_reset();
      read_cmp(18'h3_ffff);
      check(36'(ctl.load_stalls), 36'h0);
      wrap_up();
   end

   // Sixteen loads of under a hundred cycles each; this leaves wide margin.
   initial
   begin
      #200_000;
      miscompares++;
      wrap_up();
   end
endmodule
